//--- fecnt_gate.sv
/*
 Period timer for frequency measurement: emits one-cycle ticks at the
 selected interval. Assumes the fecnt_pkg package.
*/
`timescale 1ns/1ps
module fecnt_gate
#(
   parameter int unsigned CYC_10   = fecnt_pkg::CYC_10_MS,
   parameter int unsigned CYC_100  = fecnt_pkg::CYC_100_MS,
   parameter int unsigned CYC_1000 = fecnt_pkg::CYC_1000_MS
)
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // Control
   input  wire logic       enable,
   input  wire logic [1:0] period_sel,
   // Tick out
   output logic            tick
);
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic        next_tick;
   logic [31:0] limit;

   initial
   begin
      if (CYC_10 < 2 || CYC_100 < 2 || CYC_1000 < 2)
         $error("fecnt_gate: period counts must be at least 2");
   end

   always_comb
   begin
      case (period_sel)
         2'h0:    limit = CYC_10;
         2'h1:    limit = CYC_100;
         default: limit = CYC_1000;
      endcase
      next_tick = 1'b0;
      next_cnt  = cnt + 32'h0000_0001;
      if (!enable)
         next_cnt = 32'h0000_0000;
      else if (cnt >= limit - 32'h0000_0001)
      begin
         next_cnt  = 32'h0000_0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt  <= 32'h0000_0000;
         tick <= 1'b0;
      end
      else
      begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule

//--- fecnt_pkg.sv
/*
 Package for the fast event counter: register offsets, field positions,
 reset values and timing constants. Assumes a 25 MHz system clock.
*/
package fecnt_pkg;
   localparam int unsigned CLOCK_HZ      = 25_000_000;
   localparam int unsigned ADDR_W        = 4;
   // Measurement periods in milliseconds, 0.01 s / 0.1 s / 1.0 s
   localparam int unsigned PERIOD_10_MS   = 10;
   localparam int unsigned PERIOD_100_MS  = 100;
   localparam int unsigned PERIOD_1000_MS = 1000;
   localparam int unsigned CYC_10_MS   = CLOCK_HZ / 1000 * PERIOD_10_MS;
   localparam int unsigned CYC_100_MS  = CLOCK_HZ / 1000 * PERIOD_100_MS;
   localparam int unsigned CYC_1000_MS = CLOCK_HZ / 1000 * PERIOD_1000_MS;
   // Pulses per period to pulses per second
   localparam int unsigned HZ_MUL_10_MS   = 1000 / PERIOD_10_MS;
   localparam int unsigned HZ_MUL_100_MS  = 1000 / PERIOD_100_MS;
   // Register offsets
   localparam logic [3:0] REG_CTRL    = 4'h0;
   localparam logic [3:0] REG_REQ     = 4'h1;
   localparam logic [3:0] REG_NEW_CNT = 4'h2;
   localparam logic [3:0] REG_NEW_REF = 4'h3;
   localparam logic [3:0] REG_NEW_SET = 4'h4;
   localparam logic [3:0] REG_COUNT   = 4'h5;
   localparam logic [3:0] REG_REF     = 4'h6;
   localparam logic [3:0] REG_STATUS  = 4'h7;
   localparam logic [3:0] REG_MASK    = 4'h8;
   localparam logic [3:0] REG_FREQ    = 4'h9;
   // Control register fields
   localparam int unsigned CTRL_FREQ_BIT = 0;
   localparam int unsigned CTRL_RST_BIT  = 1;
   localparam int unsigned CTRL_SRC_LSB  = 2;
   // Request register fields
   localparam int unsigned REQ_DIR_BIT = 0;
   localparam int unsigned REQ_CNT_BIT = 1;
   localparam int unsigned REQ_REF_BIT = 2;
   localparam int unsigned REQ_PER_BIT = 3;
   // New-settings register fields
   localparam int unsigned SET_DIR_BIT = 0;
   localparam int unsigned SET_PER_LSB = 1;
   // Status and mask fields
   localparam int unsigned EV_MATCH_BIT = 0;
   localparam int unsigned EV_RESET_BIT = 1;
   localparam int unsigned EV_DIR_BIT   = 2;
   localparam int unsigned EV_N         = 3;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0]  PER_RESET  = 2'h0;
   localparam logic        DIR_RESET  = 1'b1;
   typedef enum logic [1:0] {FECNT_P10, FECNT_P100, FECNT_P1000} fecnt_per_t;
endpackage

//--- fecnt_pulse_src.sv
/*
 Pulse source model for the fast event counter: bursts of one-cycle pulses
 on either count line. Assumes the bench clock; lines rest low between pulses.
*/
`timescale 1ns/1ps
module fecnt_pulse_src
(
   // Clock
   input  wire logic clock,
   // Pulse lines
   output logic      pulse_a,
   output logic      pulse_b
);
   initial
   begin
      pulse_a = 1'b0;
      pulse_b = 1'b0;
   end

   // One pulse, then gap low cycles, n times
   task automatic burst(input int n, input int gap, input logic on_b);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock);
         if (on_b)
            pulse_b <= 1'b1;
         else
            pulse_a <= 1'b1;
         @(posedge clock);
         if (on_b)
            pulse_b <= 1'b0;
         else
            pulse_a <= 1'b0;
         repeat (gap - 1) @(posedge clock);
      end
   endtask

   // Hold the B line at a level, for the direction pin source
   task automatic level_b(input logic lvl);
      @(posedge clock);
      pulse_b <= lvl;
   endtask
endmodule

//--- fecnt_top.sv
/*
 Fast event counter with update requests, compare interrupt and frequency
 mode. Assumes synchronous pulse inputs already filtered, one 25 MHz clock,
 and a simple register port with read data one cycle after the strobe.
*/
`timescale 1ns/1ps
// What this block does
// - A request with the direction flag set loads the new direction.
// - A request with the count flag set overwrites the current count.
// - A request with the reference flag set loads the new reference.
// - A request with the interval flag set loads the new measurement period.
// - The measurement period only acts in frequency mode.
// - All flagged loads of one request happen in the same cycle.
// - A flag at zero leaves its parameter unchanged.
// - The match event fires when the count becomes equal to the reference.
// - The request does not return the count; the count has its own register.
// - A count read returns the value of that instant and counting goes on.
// - Mode, input source and interrupt mask are configurable.
// - Events also fire on counter reset and on direction change.
// - Frequency mode offers 10, 100 or 1000 ms periods and reports pulses/s.
// - While the reset input is active the count is cleared and held at zero.
module fecnt_top
#(
   parameter int unsigned CNT_W    = 32,
   parameter int unsigned CYC_10   = fecnt_pkg::CYC_10_MS,
   parameter int unsigned CYC_100  = fecnt_pkg::CYC_100_MS,
   parameter int unsigned CYC_1000 = fecnt_pkg::CYC_1000_MS
)
(
   // Clock and reset
   input  wire logic                               clock,
   input  wire logic                               resetn,
   // Pulse inputs
   input  wire logic                               pulse_a,
   input  wire logic                               pulse_b,
   input  wire logic                               ext_reset,
   // Register port
   input  wire logic [fecnt_pkg::ADDR_W-1:0]       reg_addr,
   input  wire logic [31:0]                        reg_wdata,
   input  wire logic                               reg_write,
   input  wire logic                               reg_read,
   output logic      [31:0]                        reg_rdata,
   // Interrupt
   output logic                                    irq
);
   initial
   begin
      if (CNT_W < 2 || CNT_W > 32)
         $error("fecnt_top: CNT_W must be 2..32");
   end

   // Control state
   logic [31:0]      ctrl, next_ctrl;
   logic [CNT_W-1:0] count, next_count;
   logic [CNT_W-1:0] refv, next_refv;
   logic [CNT_W-1:0] new_count, next_new_count;
   logic [CNT_W-1:0] new_reference, next_new_reference;
   logic             new_dir, next_new_dir;
   logic [1:0]       new_per, next_new_per;
   logic             dir, next_dir;
   logic [1:0]       period, next_period;
   logic [fecnt_pkg::EV_N-1:0] status, next_status;
   logic [fecnt_pkg::EV_N-1:0] mask, next_mask;
   logic [CNT_W-1:0] pulses, next_pulses;
   logic [31:0]      freq, next_freq;
   logic             pa_q, pb_q, rst_q;
   logic [31:0]      next_rdata;
   logic             next_irq;
   logic             tick;

   logic             freq_mode;
   logic             ext_rst_en;
   logic             req;
   logic [3:0]       req_flags;
   logic             edge_a, edge_b, step_up, step_dn;
   logic [fecnt_pkg::EV_N-1:0] events;
   logic [CNT_W-1:0] counted;
   logic [31:0]      scaled;

   // Register write decode
   function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] off);
      wr_hit = reg_write && (a == off);
   endfunction

   assign freq_mode  = ctrl[fecnt_pkg::CTRL_FREQ_BIT];
   assign ext_rst_en = ctrl[fecnt_pkg::CTRL_RST_BIT];
   assign req        = wr_hit(reg_addr, fecnt_pkg::REG_REQ);
   assign req_flags  = req ? reg_wdata[3:0] : 4'h0;
   assign edge_a     = pulse_a && !pa_q;
   assign edge_b     = pulse_b && !pb_q;

   fecnt_gate #(
      .CYC_10   (CYC_10),
      .CYC_100  (CYC_100),
      .CYC_1000 (CYC_1000)
   ) u_gate (
      .clock      (clock),
      .resetn     (resetn),
      .enable     (freq_mode),
      .period_sel (period),
      .tick       (tick)
   );

   // Source select: 0 clock+internal dir, 1 clock+dir pin, 2 up/down clocks
   always_comb
   begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case (ctrl[fecnt_pkg::CTRL_SRC_LSB +: 2])
         2'h0:
         begin
            step_up = edge_a && dir;
            step_dn = edge_a && !dir;
         end
         2'h1:
         begin
            step_up = edge_a && pulse_b;
            step_dn = edge_a && !pulse_b;
         end
         2'h2:
         begin
            step_up = edge_a && !edge_b;
            step_dn = edge_b && !edge_a;
         end
         default:
         begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
   end

   // Counting, loads and events
   always_comb
   begin
      next_ctrl          = ctrl;
      next_new_count     = new_count;
      next_new_reference = new_reference;
      next_new_dir       = new_dir;
      next_new_per       = new_per;
      next_mask          = mask;
      next_dir           = dir;
      next_period        = period;
      next_refv          = refv;
      next_freq          = freq;
      events             = '0;
      scaled             = 32'h0000_0000;
      if (wr_hit(reg_addr, fecnt_pkg::REG_CTRL))
         next_ctrl = reg_wdata;
      if (wr_hit(reg_addr, fecnt_pkg::REG_NEW_CNT))
         next_new_count = reg_wdata[CNT_W-1:0];
      if (wr_hit(reg_addr, fecnt_pkg::REG_NEW_REF))
         next_new_reference = reg_wdata[CNT_W-1:0];
      if (wr_hit(reg_addr, fecnt_pkg::REG_NEW_SET))
      begin
         next_new_dir = reg_wdata[fecnt_pkg::SET_DIR_BIT];
         next_new_per = reg_wdata[fecnt_pkg::SET_PER_LSB +: 2] > 2'h2 ? 2'h2
                        : reg_wdata[fecnt_pkg::SET_PER_LSB +: 2];
      end
      if (wr_hit(reg_addr, fecnt_pkg::REG_MASK))
         next_mask = reg_wdata[fecnt_pkg::EV_N-1:0];
      // Flagged loads all land in this one cycle; clear flags change nothing
      if (req_flags[fecnt_pkg::REQ_DIR_BIT])
         next_dir = new_dir;
      if (req_flags[fecnt_pkg::REQ_REF_BIT])
         next_refv = new_reference;
      if (req_flags[fecnt_pkg::REQ_PER_BIT])
         next_period = new_per;
      // Input edges applied on top of a count load keep every event
      counted = req_flags[fecnt_pkg::REQ_CNT_BIT] ? new_count : count;
      if (step_up)
         counted = counted + 1'b1;
      else if (step_dn)
         counted = counted - 1'b1;
      next_pulses = pulses;
      if (freq_mode)
      begin
         next_pulses = (step_up || step_dn) ? pulses + 1'b1 : pulses;
         if (tick)
         begin
            case (period)
               2'h0:    scaled = 32'(pulses) * fecnt_pkg::HZ_MUL_10_MS;
               2'h1:    scaled = 32'(pulses) * fecnt_pkg::HZ_MUL_100_MS;
               default: scaled = 32'(pulses);
            endcase
            next_freq   = scaled;
            next_pulses = (step_up || step_dn) ? CNT_W'(1) : '0;
         end
      end
      if (ext_rst_en && ext_reset)
         counted = '0;
      next_count = counted;
      events[fecnt_pkg::EV_MATCH_BIT] = (next_count == next_refv) && (count != refv || next_refv != refv
                                        || next_count != count);
      events[fecnt_pkg::EV_RESET_BIT] = ext_rst_en && ext_reset && !rst_q;
      events[fecnt_pkg::EV_DIR_BIT]   = next_dir != dir;
      // Set wins over write-one-to-clear
      next_status = status;
      if (wr_hit(reg_addr, fecnt_pkg::REG_STATUS))
         next_status = status & ~reg_wdata[fecnt_pkg::EV_N-1:0];
      next_status = next_status | events;
      next_irq    = |(next_status & next_mask);
   end

   // Read mux; the request register reads zero, the count has its own slot
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (reg_read)
      begin
         case (reg_addr)
            fecnt_pkg::REG_CTRL:    next_rdata = ctrl;
            fecnt_pkg::REG_NEW_CNT: next_rdata = 32'(new_count);
            fecnt_pkg::REG_NEW_REF: next_rdata = 32'(new_reference);
            fecnt_pkg::REG_NEW_SET: next_rdata = {29'h0, new_per, new_dir};
            fecnt_pkg::REG_COUNT:   next_rdata = 32'(count);
            fecnt_pkg::REG_REF:     next_rdata = 32'(refv);
            fecnt_pkg::REG_STATUS:  next_rdata = {28'h0, period, dir, 1'b0} | 32'(status) << 4;
            fecnt_pkg::REG_MASK:    next_rdata = 32'(mask);
            fecnt_pkg::REG_FREQ:    next_rdata = freq;
            default:                next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl          <= fecnt_pkg::CTRL_RESET;
         count         <= '0;
         refv          <= '0;
         new_count     <= '0;
         new_reference <= '0;
         new_dir       <= 1'b0;
         new_per       <= fecnt_pkg::PER_RESET;
         dir           <= fecnt_pkg::DIR_RESET;
         period        <= fecnt_pkg::PER_RESET;
         status        <= '0;
         mask          <= '0;
         pulses        <= '0;
         freq          <= 32'h0000_0000;
         pa_q          <= 1'b0;
         pb_q          <= 1'b0;
         rst_q         <= 1'b0;
         reg_rdata     <= 32'h0000_0000;
         irq           <= 1'b0;
      end
      else
      begin
         ctrl          <= next_ctrl;
         count         <= next_count;
         refv          <= next_refv;
         new_count     <= next_new_count;
         new_reference <= next_new_reference;
         new_dir       <= next_new_dir;
         new_per       <= next_new_per;
         dir           <= next_dir;
         period        <= next_period;
         status        <= next_status;
         mask          <= next_mask;
         pulses        <= next_pulses;
         freq          <= next_freq;
         pa_q          <= pulse_a;
         pb_q          <= pulse_b;
         rst_q         <= ext_rst_en && ext_reset;
         reg_rdata     <= next_rdata;
         irq           <= next_irq;
      end
   end

   property p_load_count;
      @(posedge clock) disable iff (!resetn)
      req && reg_wdata[1] && !step_up && !step_dn && !(ext_rst_en && ext_reset) |=> count == $past(new_count);
   endproperty
   a_load_count: assert property (p_load_count) else $error("count load missed");

   property p_load_ref;
      @(posedge clock) disable iff (!resetn)
      req && reg_wdata[2] |=> refv == $past(new_reference);
   endproperty
   a_load_ref: assert property (p_load_ref) else $error("reference load missed");

   property p_load_dir;
      @(posedge clock) disable iff (!resetn)
      req && reg_wdata[0] |=> dir == $past(new_dir);
   endproperty
   a_load_dir: assert property (p_load_dir) else $error("direction load missed");

   property p_load_per;
      @(posedge clock) disable iff (!resetn)
      req && reg_wdata[3] |=> period == $past(new_per);
   endproperty
   a_load_per: assert property (p_load_per) else $error("period load missed");

   property p_hold;
      @(posedge clock) disable iff (!resetn)
      !req |=> $stable(refv) && $stable(dir) && $stable(period);
   endproperty
   a_hold: assert property (p_hold) else $error("parameter changed without request");

   property p_match;
      @(posedge clock) disable iff (!resetn)
      $changed(count) && count == refv && !(reg_write && reg_addr == fecnt_pkg::REG_STATUS)
      |=> status[fecnt_pkg::EV_MATCH_BIT];
   endproperty
   a_match: assert property (p_match) else $error("match event missed");

   property p_ext_rst;
      @(posedge clock) disable iff (!resetn)
      ext_rst_en && ext_reset |=> count == '0;
   endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("count not held at zero");

   property p_count_up;
      @(posedge clock) disable iff (!resetn)
      step_up && !req && !(ext_rst_en && ext_reset) |=> count == $past(count) + 1'b1;
   endproperty
   a_count_up: assert property (p_count_up) else $error("event lost");

   property p_read;
      @(posedge clock) disable iff (!resetn)
      reg_read && reg_addr == fecnt_pkg::REG_COUNT |=> reg_rdata == 32'($past(count));
   endproperty
   a_read: assert property (p_read) else $error("count read wrong");

   property p_irq;
      @(posedge clock) disable iff (!resetn)
      |(status & mask) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   c_multi: cover property (@(posedge clock) disable iff (!resetn) req && reg_wdata[3:0] == 4'hf);
   c_match: cover property (@(posedge clock) disable iff (!resetn) events[fecnt_pkg::EV_MATCH_BIT]);
   c_freq:  cover property (@(posedge clock) disable iff (!resetn) tick && freq_mode);
endmodule

//--- fecnt_top_bench.sv
/*
 Self-checking bench for the fast event counter: register tasks, a pulse
 source model and random loads. Assumes short frequency periods in sim.
*/
`timescale 1ns/1ps
module fecnt_top_bench;
   localparam int unsigned C10  = 40;
   localparam int unsigned C100 = 200;
   localparam int unsigned C1000 = 1000;
   // Design ports
   logic                          clock;
   logic                          resetn;
   logic                          pulse_a;
   logic                          pulse_b;
   logic                          ext_reset;
   logic [fecnt_pkg::ADDR_W-1:0]  reg_addr;
   logic [31:0]                   reg_wdata;
   logic                          reg_write;
   logic                          reg_read;
   logic [31:0]                   reg_rdata;
   logic                          irq;
   // Bench state
   int                            error_cnt;
   int                            samples_checked;
   logic [31:0]                   seed;
   logic [31:0]                   d;
   logic [31:0]                   v;
   logic [31:0]                   r;
   int                            n;
   int                            m;
   logic                          dn;

   fecnt_top #(.CNT_W(32), .CYC_10(C10), .CYC_100(C100), .CYC_1000(C1000)) fecnt_top_inst
   (
      .clock(clock), .resetn(resetn), .pulse_a(pulse_a), .pulse_b(pulse_b), .ext_reset(ext_reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .irq(irq)
   );
   fecnt_pulse_src fecnt_pulse_src_inst (.clock(clock), .pulse_a(pulse_a), .pulse_b(pulse_b));

   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic idle(input int k);
      repeat (k) @(posedge clock);
   endtask

   task automatic wr(input logic [fecnt_pkg::ADDR_W-1:0] a, input logic [31:0] w);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= w;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic rd(input logic [fecnt_pkg::ADDR_W-1:0] a, output logic [31:0] q);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(posedge clock);
      q = reg_rdata;
   endtask

   // Match within a tolerance; zero tolerance is an exact match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] tol = 0);
      logic ok;
      ok = (got + tol >= exp) && (got <= exp + tol);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic results();
      $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      #(40 * 40000);
      error_cnt++;
      results();
   end

   initial
   begin
      resetn = 1'b0;
      ext_reset = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      error_cnt = 0;
      samples_checked = 0;
      seed = 32'h0001_7E02;
      repeat (3) @(posedge clock);
      resetn <= 1'b1;
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, 32'h0000_0000);
      rd(fecnt_pkg::REG_STATUS, d);
      chk(d & 32'h0000_000E, 32'h0000_0002);
      rd(fecnt_pkg::REG_REQ, d);
      chk(d, 32'h0000_0000);
      rd(4'hF, d);
      chk(d, 32'h0000_0000);
      // Random count and direction loads with pulse bursts
      seed = lfsr(seed);
      r = seed;
      wr(fecnt_pkg::REG_NEW_REF, r);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0004);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         v = seed;
         seed = lfsr(seed);
         n = 1 + seed[2:0];
         dn = seed[3];
         wr(fecnt_pkg::REG_NEW_CNT, v);
         wr(fecnt_pkg::REG_NEW_SET, {31'h0, ~dn});
         wr(fecnt_pkg::REG_REQ, 32'h0000_0003);
         fecnt_pulse_src_inst.burst(n, 1 + seed[5:4], 1'b0);
         idle(3);
         rd(fecnt_pkg::REG_COUNT, d);
         chk(d, dn ? v - 32'(n) : v + 32'(n));
         rd(fecnt_pkg::REG_REF, d);
         chk(d, r);
      end
      // Compare match, interrupt, handler reload
      wr(fecnt_pkg::REG_NEW_SET, 32'h0000_0001);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0001);
      wr(fecnt_pkg::REG_MASK, 32'h0000_0001);
      seed = lfsr(seed);
      v = seed;
      wr(fecnt_pkg::REG_NEW_REF, v);
      wr(fecnt_pkg::REG_NEW_CNT, v - 32'h0000_0003);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0006);
      wr(fecnt_pkg::REG_STATUS, 32'h0000_0007);
      fecnt_pulse_src_inst.burst(2, 1, 1'b0);
      idle(3);
      chk(irq, 32'h0000_0000);
      fecnt_pulse_src_inst.burst(1, 1, 1'b0);
      idle(3);
      chk(irq, 32'h0000_0001);
      rd(fecnt_pkg::REG_STATUS, d);
      chk(d & 32'h0000_0010, 32'h0000_0010);
      wr(fecnt_pkg::REG_NEW_REF, v + 32'h0000_0002);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0004);
      wr(fecnt_pkg::REG_STATUS, 32'h0000_0001);
      idle(2);
      chk(irq, 32'h0000_0000);
      fecnt_pulse_src_inst.burst(2, 1, 1'b0);
      idle(3);
      chk(irq, 32'h0000_0001);
      wr(fecnt_pkg::REG_MASK, 32'h0000_0000);
      idle(2);
      chk(irq, 32'h0000_0000);
      // Direction change event, and none when unchanged
      wr(fecnt_pkg::REG_STATUS, 32'h0000_0007);
      wr(fecnt_pkg::REG_NEW_SET, 32'h0000_0000);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0001);
      rd(fecnt_pkg::REG_STATUS, d);
      chk(d & 32'h0000_0042, 32'h0000_0040);
      wr(fecnt_pkg::REG_STATUS, 32'h0000_0007);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0001);
      rd(fecnt_pkg::REG_STATUS, d);
      chk(d & 32'h0000_0040, 32'h0000_0000);
      // Up and down clock inputs
      wr(fecnt_pkg::REG_NEW_CNT, 32'h0000_0064);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0002);
      wr(fecnt_pkg::REG_CTRL, 32'h0000_0008);
      fecnt_pulse_src_inst.burst(4, 2, 1'b0);
      fecnt_pulse_src_inst.burst(2, 2, 1'b1);
      idle(3);
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, 32'h0000_0066);
      // Clock plus direction pin
      wr(fecnt_pkg::REG_CTRL, 32'h0000_0004);
      fecnt_pulse_src_inst.burst(3, 1, 1'b0);
      fecnt_pulse_src_inst.level_b(1'b1);
      fecnt_pulse_src_inst.burst(5, 1, 1'b0);
      fecnt_pulse_src_inst.level_b(1'b0);
      idle(3);
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, 32'h0000_0068);
      // Read while counting goes on
      wr(fecnt_pkg::REG_CTRL, 32'h0000_0000);
      wr(fecnt_pkg::REG_NEW_SET, 32'h0000_0001);
      wr(fecnt_pkg::REG_NEW_CNT, 32'h0000_0000);
      wr(fecnt_pkg::REG_REQ, 32'h0000_0003);
      fork
         fecnt_pulse_src_inst.burst(20, 3, 1'b0);
         begin
            idle(30);
            rd(fecnt_pkg::REG_COUNT, v);
         end
      join
      idle(3);
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, 32'h0000_0014);
      chk(v, 32'h0000_000A, 32'h0000_0009);
      // External reset holds the count at zero
      wr(fecnt_pkg::REG_CTRL, 32'h0000_0002);
      wr(fecnt_pkg::REG_STATUS, 32'h0000_0007);
      ext_reset <= 1'b1;
      fecnt_pulse_src_inst.burst(3, 1, 1'b0);
      idle(3);
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, 32'h0000_0000);
      rd(fecnt_pkg::REG_STATUS, d);
      chk(d & 32'h0000_0020, 32'h0000_0020);
      ext_reset <= 1'b0;
      fecnt_pulse_src_inst.burst(3, 1, 1'b0);
      idle(3);
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, 32'h0000_0003);
      // Period selection, code 3 clamps to 2
      for (int p = 0; p < 4; p++)
      begin
         wr(fecnt_pkg::REG_NEW_SET, 32'(p << 1));
         wr(fecnt_pkg::REG_REQ, 32'h0000_0008);
         rd(fecnt_pkg::REG_STATUS, d);
         chk(d & 32'h0000_000C, 32'((p > 2 ? 2 : p) << 2));
      end
      // All four loads in one request
      seed = lfsr(seed);
      wr(fecnt_pkg::REG_NEW_CNT, seed);
      wr(fecnt_pkg::REG_NEW_REF, ~seed);
      wr(fecnt_pkg::REG_NEW_SET, 32'h0000_0002);
      wr(fecnt_pkg::REG_REQ, 32'h0000_000F);
      rd(fecnt_pkg::REG_COUNT, d);
      chk(d, seed);
      rd(fecnt_pkg::REG_REF, d);
      chk(d, ~seed);
      rd(fecnt_pkg::REG_STATUS, d);
      chk(d & 32'h0000_000E, 32'h0000_0004);
      // Frequency mode, one pulse every 4 cycles
      wr(fecnt_pkg::REG_CTRL, 32'h0000_0001);
      for (int p = 0; p < 3; p++)
      begin
         n = p == 2 ? C1000 : p ? C100 : C10;
         m = p == 2 ? 1000 / fecnt_pkg::PERIOD_1000_MS : p ? fecnt_pkg::HZ_MUL_100_MS : fecnt_pkg::HZ_MUL_10_MS;
         wr(fecnt_pkg::REG_NEW_SET, 32'(p << 1));
         wr(fecnt_pkg::REG_REQ, 32'h0000_0008);
         fork
            fecnt_pulse_src_inst.burst(3 * n / 4, 3, 1'b0);
            begin
               idle(5 * n / 2);
               rd(fecnt_pkg::REG_FREQ, d);
            end
         join
         chk(d, 32'(n / 4 * m), 32'(m));
      end
      results();
   end
endmodule
